// *** logic/restart_interlock_control.sv ***
// Receiver start-up and restart interlock controller with APB registers.
// Assumes optical inputs and button pins are synchronous to pclk.
// Behaviour
// - Self test first, then show response time
// - Ready: primary lamp steady green or red
// - Marginal beams with alignment: flash green, segments
// - Clear field, no lock: green, outputs on
// - Interlock engaged: red lamp, outputs off
// - Yellow lamp when field clear, interlock enabled
// - Release after 0.15 to 4 s unlocks
// - Hold 4 s or longer: request discarded
// - Hold 30 s: shorted input, fault state
// - Interruption or power loss engages interlock when the select input is high
// - Button line lamp is inverted outputs
//
// The APB slave port and the register addresses are this design's own decisions.
`include "restart_interlock_defs.svh"
module restart_interlock_control #(
    parameter int SELFTEST_CYCLES = 25000,
    parameter int MIN_HOLD_CYCLES = `RIC_MIN_HOLD_MS * `RIC_CYC_PER_MS,
    parameter int MAX_HOLD_CYCLES = `RIC_MAX_HOLD_MS * `RIC_CYC_PER_MS,
    parameter int SHORT_HOLD_CYCLES = `RIC_SHORT_HOLD_MS * `RIC_CYC_PER_MS,
    parameter int BLINK_CYCLES = `RIC_BLINK_MS * `RIC_CYC_PER_MS
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Optical receiver condition
    input wire logic field_clear,
    input wire logic beams_marginal,
    // Interlock select and reset button line
    input wire logic interlock_select_input,
    input wire logic reset_button_line_in,
    output logic reset_button_line_out,
    output logic reset_button_line_oe,
    // Safety switching outputs
    output logic safety_switching_output1,
    output logic safety_switching_output2,
    // Indicators
    output logic primary_status_lamp_green,
    output logic primary_status_lamp_red,
    output logic yellow_lamp,
    output logic [7:0] display_value,
    output logic display_lit,
    // Interrupt
    output logic irq
);
    restart_interlock_pkg::op_state_t state_ff;
    restart_interlock_pkg::op_state_t nxt_state;
    logic [31:0] st_cnt_ff;
    logic [31:0] nxt_st_cnt;
    logic align_en_ff;
    logic nxt_align_en;
    logic [7:0] resp_time_ff;
    logic [7:0] nxt_resp_time;
    logic [`RIC_IRQ_W-1:0] irq_stat_ff;
    logic [`RIC_IRQ_W-1:0] nxt_irq_stat;
    logic [`RIC_IRQ_W-1:0] irq_mask_ff;
    logic [`RIC_IRQ_W-1:0] nxt_irq_mask;
    logic [`RIC_IRQ_W-1:0] events;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic pready_ff;
    logic pslverr_ff;
    logic nxt_pslverr;
    logic irq_ff;
    logic safety_switching_output_ff;
    logic nxt_safety_switching_output;
    logic green_ff;
    logic nxt_green;
    logic red_ff;
    logic nxt_red;
    logic yellow_ff;
    logic nxt_yellow;
    logic [7:0] disp_ff;
    logic [7:0] nxt_disp;
    logic lit_ff;
    logic nxt_lit;
    logic btn_lamp_ff;
    logic btn_oe_ff;
    logic valid_release;
    logic discard;
    logic shorted;
    logic blink;
    logic res_en;
    logic setup;
    logic access_wr;
    logic access_rd;
    logic addr_ok;

    // Select input high means interlock in use; bridged low to button line means not
    assign res_en = interlock_select_input;

    // Button only counts while it is an input
    press_timer #(
        .MIN_CYCLES(MIN_HOLD_CYCLES),
        .MAX_CYCLES(MAX_HOLD_CYCLES),
        .SHORT_CYCLES(SHORT_HOLD_CYCLES)
    ) u_press (
        .pclk(pclk),
        .presetn(presetn),
        .pressed(reset_button_line_in & res_en),
        .valid_release(valid_release),
        .discard(discard),
        .shorted(shorted)
    );

    blink_timer #(
        .HALF_CYCLES(BLINK_CYCLES)
    ) u_blink (
        .pclk(pclk),
        .presetn(presetn),
        .phase(blink)
    );

    // Operating state machine
    always_comb
    begin
        nxt_state = state_ff;
        nxt_st_cnt = st_cnt_ff;
        events = `RIC_IRQ_RESET;
        case (state_ff)
            restart_interlock_pkg::ST_SELFTEST:
            begin
                nxt_st_cnt = st_cnt_ff + 32'h1;
                if (st_cnt_ff >= 32'(SELFTEST_CYCLES - 1))
                begin
                    // Power return counts as a supply failure: start locked
                    nxt_state = restart_interlock_pkg::ST_LOCKED;
                    events[`RIC_EV_LOCKED] = 1'b1;
                end
            end
            restart_interlock_pkg::ST_ON:
            begin
                if (!field_clear)
                begin
                    nxt_state = restart_interlock_pkg::ST_LOCKED;
                    events[`RIC_EV_LOCKED] = 1'b1;
                end
            end
            restart_interlock_pkg::ST_LOCKED:
            begin
                if (shorted)
                begin
                    nxt_state = restart_interlock_pkg::ST_FAULT;
                    events[`RIC_EV_FAULT] = 1'b1;
                end
                else if (field_clear && (!res_en || valid_release))
                begin
                    nxt_state = restart_interlock_pkg::ST_ON;
                    events[`RIC_EV_UNLOCKED] = 1'b1;
                end
                events[`RIC_EV_DISCARD] = discard;
            end
            restart_interlock_pkg::ST_FAULT:
                nxt_state = restart_interlock_pkg::ST_FAULT; // Left only by reset
            default:
                nxt_state = restart_interlock_pkg::ST_SELFTEST;
        endcase
        // A short while running is still a fault
        if (shorted && state_ff == restart_interlock_pkg::ST_ON)
        begin
            nxt_state = restart_interlock_pkg::ST_FAULT;
            events[`RIC_EV_FAULT] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= restart_interlock_pkg::ST_SELFTEST;
            st_cnt_ff <= 32'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            st_cnt_ff <= nxt_st_cnt;
        end
    end

    // Outputs and indicators, all registered so no decode glitch reaches a pin
    always_comb
    begin
        nxt_safety_switching_output = (nxt_state == restart_interlock_pkg::ST_ON);
        nxt_green = 1'b0;
        nxt_red = 1'b0;
        nxt_yellow = 1'b0;
        nxt_disp = 8'h00;
        nxt_lit = 1'b0;
        if (state_ff != restart_interlock_pkg::ST_SELFTEST)
        begin
            nxt_disp = resp_time_ff;
            nxt_lit = 1'b1;
            nxt_yellow = field_clear && res_en;
            if (state_ff == restart_interlock_pkg::ST_ON)
            begin
                nxt_green = 1'b1;
                if (align_en_ff && beams_marginal)
                begin
                    nxt_green = blink;
                    nxt_lit = blink;
                end
            end
            else
                nxt_red = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            safety_switching_output_ff <= 1'b0;
            green_ff <= 1'b0;
            red_ff <= 1'b0;
            yellow_ff <= 1'b0;
            disp_ff <= 8'h00;
            lit_ff <= 1'b0;
            btn_lamp_ff <= 1'b1;
            btn_oe_ff <= 1'b0;
        end
        else
        begin
            safety_switching_output_ff <= nxt_safety_switching_output;
            green_ff <= nxt_green;
            red_ff <= nxt_red;
            yellow_ff <= nxt_yellow;
            disp_ff <= nxt_disp;
            lit_ff <= nxt_lit;
            btn_lamp_ff <= ~nxt_safety_switching_output;
            btn_oe_ff <= ~res_en; // Drives only when no button is wired
        end
    end

    // APB decode: setup phase prepares the answer, access phase finishes in one cycle
    assign setup = psel && !penable;
    assign access_wr = psel && penable && pready_ff && pwrite && !pslverr_ff;
    assign access_rd = psel && penable && pready_ff && !pwrite && !pslverr_ff;
    always_comb
    begin
        addr_ok = 1'b1;
        nxt_prdata = 32'h0;
        if (paddr == `RIC_ADDR_CTRL)
            nxt_prdata[`RIC_CTRL_ALIGN_BIT] = align_en_ff;
        else if (paddr == `RIC_ADDR_STATUS)
            nxt_prdata = {24'h0, safety_switching_output_ff, res_en, field_clear, 1'b0, state_ff};
        else if (paddr == `RIC_ADDR_IRQ_STAT)
            nxt_prdata = {28'h0, irq_stat_ff};
        else if (paddr == `RIC_ADDR_IRQ_MASK)
            nxt_prdata = {28'h0, irq_mask_ff};
        else if (paddr == `RIC_ADDR_RESP_TIME)
            nxt_prdata = {24'h0, resp_time_ff};
        else
            addr_ok = 1'b0;
        nxt_pslverr = setup && !addr_ok;
    end

    // Register writes; read of interrupt status clears, but a new event wins
    always_comb
    begin
        nxt_align_en = align_en_ff;
        nxt_resp_time = resp_time_ff;
        nxt_irq_mask = irq_mask_ff;
        nxt_irq_stat = irq_stat_ff;
        if (access_wr && paddr == `RIC_ADDR_CTRL)
            nxt_align_en = pwdata[`RIC_CTRL_ALIGN_BIT];
        if (access_wr && paddr == `RIC_ADDR_IRQ_MASK)
            nxt_irq_mask = pwdata[`RIC_IRQ_W-1:0];
        if (access_wr && paddr == `RIC_ADDR_RESP_TIME)
            nxt_resp_time = pwdata[7:0];
        if (access_rd && paddr == `RIC_ADDR_IRQ_STAT)
            nxt_irq_stat = `RIC_IRQ_RESET;
        nxt_irq_stat = nxt_irq_stat | events;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            align_en_ff <= `RIC_CTRL_RESET;
            resp_time_ff <= `RIC_RESP_TIME_RESET;
            irq_mask_ff <= `RIC_IRQ_RESET;
            irq_stat_ff <= `RIC_IRQ_RESET;
            prdata_ff <= 32'h0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            irq_ff <= 1'b0;
        end
        else
        begin
            align_en_ff <= nxt_align_en;
            resp_time_ff <= nxt_resp_time;
            irq_mask_ff <= nxt_irq_mask;
            irq_stat_ff <= nxt_irq_stat;
            prdata_ff <= setup ? nxt_prdata : 32'h0;
            pready_ff <= setup;
            pslverr_ff <= nxt_pslverr;
            irq_ff <= |(nxt_irq_stat & nxt_irq_mask);
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;
    assign safety_switching_output1 = safety_switching_output_ff;
    assign safety_switching_output2 = safety_switching_output_ff;
    assign primary_status_lamp_green = green_ff;
    assign primary_status_lamp_red = red_ff;
    assign yellow_lamp = yellow_ff;
    assign display_value = disp_ff;
    assign display_lit = lit_ff;
    assign reset_button_line_out = btn_lamp_ff;
    assign reset_button_line_oe = btn_oe_ff;
endmodule : restart_interlock_control

// *** logic/restart_interlock_defs.svh ***
// Constants for the restart interlock controller: register offsets, fields, timings.
// Assumes inclusion by bare name from design files only.
`ifndef RESTART_INTERLOCK_DEFS_SVH
`define RESTART_INTERLOCK_DEFS_SVH

// Clock rate
`define RIC_CLK_HZ 25000000
`define RIC_CYC_PER_MS (`RIC_CLK_HZ / 1000)

// Reset button hold times in milliseconds
`define RIC_MIN_HOLD_MS 150
`define RIC_MAX_HOLD_MS 4000
`define RIC_SHORT_HOLD_MS 30000

// Lamp and segment flash half period in milliseconds
`define RIC_BLINK_MS 250

// Register byte offsets
`define RIC_ADDR_CTRL 8'h00
`define RIC_ADDR_STATUS 8'h04
`define RIC_ADDR_IRQ_STAT 8'h08
`define RIC_ADDR_IRQ_MASK 8'h0c
`define RIC_ADDR_RESP_TIME 8'h10

// Control fields
`define RIC_CTRL_ALIGN_BIT 0
`define RIC_CTRL_RESET 1'h0
`define RIC_RESP_TIME_RESET 8'h00

// Interrupt event bits
`define RIC_IRQ_W 4
`define RIC_EV_LOCKED 0
`define RIC_EV_UNLOCKED 1
`define RIC_EV_DISCARD 2
`define RIC_EV_FAULT 3
`define RIC_IRQ_RESET 4'h0

`endif

// *** logic/restart_interlock_pkg.sv ***
// Types shared by the restart interlock controller.
// Assumes nothing of its surroundings.
package restart_interlock_pkg;

    // Main operating states, one-hot
    typedef enum logic [3:0] {
        ST_SELFTEST = 4'h1,
        ST_ON = 4'h2,
        ST_LOCKED = 4'h4,
        ST_FAULT = 4'h8
    } op_state_t;

endpackage : restart_interlock_pkg

// *** logic/blink_timer.sv ***
// Free running flash phase generator for lamps and segments.
// Assumes one clock, asynchronous active-low reset.
module blink_timer #(
    parameter int HALF_CYCLES = 6250000
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Flash phase
    output logic phase
);
    logic [31:0] cnt_ff;
    logic [31:0] nxt_cnt;
    logic phase_ff;
    logic nxt_phase;

    // Toggle phase each half period
    always_comb
    begin
        nxt_cnt = cnt_ff + 32'h1;
        nxt_phase = phase_ff;
        if (cnt_ff >= 32'(HALF_CYCLES - 1))
        begin
            nxt_cnt = 32'h0;
            nxt_phase = ~phase_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_ff <= 32'h0;
            phase_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            phase_ff <= nxt_phase;
        end
    end

    assign phase = phase_ff;
endmodule : blink_timer

// *** logic/press_timer.sv ***
// Measures reset button hold time and classifies each press.
// Assumes the button level is synchronous to pclk.
module press_timer #(
    parameter int MIN_CYCLES = 3750000,
    parameter int MAX_CYCLES = 100000000,
    parameter int SHORT_CYCLES = 750000000
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Button level, high while pressed
    input wire logic pressed,
    // Classification pulses
    output logic valid_release,
    output logic discard,
    output logic shorted
);
    logic [31:0] cnt_ff;
    logic [31:0] nxt_cnt;
    logic prev_ff;
    logic nxt_prev;
    logic valid_ff;
    logic nxt_valid;
    logic disc_ff;
    logic nxt_disc;
    logic short_ff;
    logic nxt_short;

    // Count from press; judge valid on release, discard and short while held; saturate at the short limit
    always_comb
    begin
        nxt_prev = pressed;
        nxt_cnt = cnt_ff;
        nxt_valid = 1'b0;
        nxt_disc = 1'b0;
        nxt_short = 1'b0;
        if (pressed)
        begin
            if (!prev_ff)
                nxt_cnt = 32'h1;
            else if (cnt_ff < 32'(SHORT_CYCLES))
                nxt_cnt = cnt_ff + 32'h1;
            nxt_disc = prev_ff && (cnt_ff == 32'(MAX_CYCLES - 1));
            nxt_short = prev_ff && (cnt_ff == 32'(SHORT_CYCLES - 1));
        end
        else if (prev_ff)
        begin
            // Too short or too long releases give nothing
            nxt_valid = (cnt_ff >= 32'(MIN_CYCLES)) && (cnt_ff < 32'(MAX_CYCLES));
            nxt_cnt = 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_ff <= 32'h0;
            prev_ff <= 1'b0;
            valid_ff <= 1'b0;
            disc_ff <= 1'b0;
            short_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            prev_ff <= nxt_prev;
            valid_ff <= nxt_valid;
            disc_ff <= nxt_disc;
            short_ff <= nxt_short;
        end
    end

    assign valid_release = valid_ff;
    assign discard = disc_ff;
    assign shorted = short_ff;
endmodule : press_timer

// *** tb/restart_interlock_control_sva.sv ***
// Checker for the restart interlock controller, bound to its top ports.
// Assumes one clock domain, presetn asynchronous and active low.
module ric_checker #(
    parameter int MIN_HOLD_CYCLES = 15,
    parameter int MAX_HOLD_CYCLES = 40,
    parameter int SHORT_HOLD_CYCLES = 100
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Field, select and button line
    input wire logic field_clear,
    input wire logic interlock_select_input,
    input wire logic reset_button_line_in,
    input wire logic reset_button_line_out,
    // Outputs and lamps
    input wire logic safety_switching_output1,
    input wire logic safety_switching_output2,
    input wire logic primary_status_lamp_red,
    input wire logic yellow_lamp
);
    int hold_ff;
    int nxt_hold;
    logic lost_ff;
    logic nxt_lost;
    wire logic so = safety_switching_output1;
    wire logic pr = reset_button_line_in && interlock_select_input;

    // Press length; counts the same edges as the hold counter, so limits are exact
    always_comb
    begin
        nxt_hold = pr ? hold_ff + 1 : 0;
        nxt_lost = lost_ff || hold_ff >= SHORT_HOLD_CYCLES;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hold_ff <= 0;
            lost_ff <= 1'b0;
        end
        else
        begin
            hold_ff <= nxt_hold;
            lost_ff <= nxt_lost;
        end
    end

    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    safety_switching_output_pair_a: assert property (
        so == safety_switching_output2) else $error("safety outputs disagree");
    lamp_inverse_a: assert property (
        so == $past(so) |-> reset_button_line_out != so) else $error("button lamp wrong");
    red_off_a: assert property (
        so && $past(so) |-> !primary_status_lamp_red) else $error("red lamp with outputs on");
    field_drop_a: assert property (
        so && !field_clear |=> !so) else $error("outputs stay on after interruption");
    yellow_ready_a: assert property (
        yellow_lamp |-> $past(field_clear && interlock_select_input)) else $error("yellow lamp");
    valid_unlock_a: assert property (
        $fell(pr) && hold_ff >= MIN_HOLD_CYCLES && hold_ff < MAX_HOLD_CYCLES
        && field_clear && !so && !lost_ff |-> ##[1:4] so) else $error("valid press ignored");
    short_press_a: assert property (
        $fell(pr) && hold_ff < MIN_HOLD_CYCLES && !so |=> !so [*4])
        else $error("short press unlocked");
    long_press_a: assert property (
        $fell(pr) && hold_ff >= MAX_HOLD_CYCLES && !so |=> !so [*4])
        else $error("long press unlocked");
    shorted_lock_a: assert property (
        lost_ff |-> !so) else $error("outputs on after shorted input");
    bus_ready_a: assert property (
        psel && !penable |=> pready) else $error("no ready after setup");
    bus_error_a: assert property (
        pslverr |-> pready) else $error("error without ready");

    unlock_c: cover property ($rose(so));
    drop_c: cover property (so && !field_clear);
    fault_c: cover property (lost_ff);
endmodule : ric_checker

bind restart_interlock_control ric_checker #(
    .MIN_HOLD_CYCLES(MIN_HOLD_CYCLES),
    .MAX_HOLD_CYCLES(MAX_HOLD_CYCLES),
    .SHORT_HOLD_CYCLES(SHORT_HOLD_CYCLES)
) ric_checker_inst (
    .pclk, .presetn, .psel, .penable, .pready, .pslverr, .field_clear,
    .interlock_select_input, .reset_button_line_in, .reset_button_line_out,
    .safety_switching_output1, .safety_switching_output2,
    .primary_status_lamp_red, .yellow_lamp
);

// *** tb/button_relay_model.sv ***
// Operator reset button and downstream safety relay.
// Assumes the bench calls press from its own thread.
module button_relay_model (
    // Clock
    input wire logic pclk,
    // Button line
    input wire logic line_out,
    input wire logic line_oe,
    output logic line_in,
    // Safety outputs into the relay
    input wire logic ossd1,
    input wire logic ossd2,
    output logic relay_on
);
    timeunit 1ns;
    timeprecision 1ns;
    logic pressed = 1'b0;

    // Lamp drive wins while the select input is bridged to the line
    assign line_in = line_oe ? line_out : pressed;
    // Relay pulls in only while both channels are on
    always_ff @(posedge pclk) relay_on <= ossd1 & ossd2;

    // Hold the button for n edges, then let it spring back low
    task press(input int n);
        @(posedge pclk);
        pressed <= 1'b1;
        repeat (n) @(posedge pclk);
        pressed <= 1'b0;
    endtask : press
endmodule : button_relay_model

// *** tb/restart_interlock_control_tb_top.sv ***
// Self-checking bench for the restart interlock controller.
// Assumes shortened hold counts: min 15, max 40, short 100 cycles.
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module restart_interlock_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, fc, bm, sel, lin, lo, loe;
    logic so1, so2, grn, red, yel, dl, irq, relay, er;
    logic [7:0] paddr, dv;
    logic [31:0] pwdata, prdata, rd;
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;

    always #20 pclk = ~pclk;

    restart_interlock_control #(.SELFTEST_CYCLES(10), .MIN_HOLD_CYCLES(15),
        .MAX_HOLD_CYCLES(40), .SHORT_HOLD_CYCLES(100), .BLINK_CYCLES(4)
    ) restart_interlock_control_inst (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .field_clear(fc), .beams_marginal(bm),
        .interlock_select_input(sel), .reset_button_line_in(lin),
        .reset_button_line_out(lo), .reset_button_line_oe(loe),
        .safety_switching_output1(so1), .safety_switching_output2(so2),
        .primary_status_lamp_green(grn), .primary_status_lamp_red(red), .yellow_lamp(yel),
        .display_value(dv), .display_lit(dl), .irq);
    button_relay_model button_relay_model_inst (.pclk, .line_out(lo), .line_oe(loe),
        .line_in(lin), .ossd1(so1), .ossd2(so2), .relay_on(relay));

    // One bus transfer; a leading edge keeps back-to-back calls apart
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No own limit: only the bench timeout may end this wait
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task s_power;
        repeat (3) @(posedge pclk);
        `CHK({red, dl, dv}, 10'h000)
        repeat (15) @(posedge pclk);
        `CHK({red, grn, so1, lo, yel, dl}, 6'b100111)
        apb(1'b1, 8'h10, 32'h0000003c);
        repeat (2) @(posedge pclk);
        `CHK(dv, 8'h3c)
    endtask : s_power

    task s_regs;
        apb(1'b0, 8'h04, 32'h0);
        `CHK(rd, 32'h00000064)
        apb(1'b0, 8'h0c, 32'h0);
        `CHK(rd, 32'h00000000)
        apb(1'b0, 8'h20, 32'h0);
        `CHK({er, rd}, 33'h100000000)
        apb(1'b0, 8'h08, 32'h0);
        `CHK(rd, 32'h00000001)
        apb(1'b1, 8'h0c, 32'h00000006);
    endtask : s_regs

    task s_press(input int n, input logic on);
        button_relay_model_inst.press(n);
        repeat (8) @(posedge pclk);
        `CHK(so1, on)
    endtask : s_press

    task s_unlock;
        s_press(15, 1'b1);
        `CHK({so2, grn, red, lo, relay, irq}, 6'b110011)
        apb(1'b0, 8'h08, 32'h0);
        repeat (2) @(posedge pclk);
        `CHK({rd[1], irq}, 2'b10)
    endtask : s_unlock

    task s_align;
        logic [3:0] seen;
        seen = 4'h0;
        apb(1'b1, 8'h00, 32'h00000001);
        bm <= 1'b1;
        repeat (12)
        begin
            @(posedge pclk);
            seen = seen | {grn, !grn, dl, !dl};
        end
        `CHK(seen, 4'hf)
        bm <= 1'b0;
        apb(1'b1, 8'h00, 32'h0);
    endtask : s_align

    task drop_field;
        @(posedge pclk);
        fc <= 1'b0;
        @(posedge pclk);
        fc <= 1'b1;
        repeat (6) @(posedge pclk);
    endtask : drop_field

    task s_rest;
        drop_field;
        `CHK({so1, red, lo, yel}, 4'b0111)
        s_press(40, 1'b0);
        `CHK(irq, 1'b1)
        apb(1'b0, 8'h08, 32'h0);
        `CHK(rd[2], 1'b1)
        sel <= 1'b0;
        drop_field;
        `CHK({so1, loe}, 2'b11)
        sel <= 1'b1;
        drop_field;
        `CHK(so1, 1'b0)
        s_press(110, 1'b0);
        apb(1'b0, 8'h04, 32'h0);
        `CHK(rd[3:0], 4'h8)
        s_press(20, 1'b0);
    endtask : s_rest

    // Supply loss in mid-run: fault is left, block restarts locked
    task s_repower;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (16) @(posedge pclk);
        `CHK({so1, red, dl}, 3'b011)
        s_press(15, 1'b1);
    endtask : s_repower

    task close_out;
        $display("mismatches %0d comparisons %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out

    // Cut a hang short well past the longest expected run
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            err_total++;
            close_out;
        end
    end

    // Reset, then scenarios in order; each leaves the block in a known state
    initial
    begin
        {presetn, psel, penable, pwrite, bm, paddr, pwdata} = '0;
        {fc, sel} = 2'b11;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        s_power;
        s_regs;
        s_press(14, 1'b0);
        s_unlock;
        s_align;
        s_rest;
        s_repower;
        close_out;
    end
endmodule : restart_interlock_control_tb_top
